// ### mbs_link_if.sv
// Purpose: character link between master and slave
// Assumes: both ends on the same clock
// Notes: master to slave has no back-pressure, like a serial line
interface mbs_link_if;
  logic m2sValid;
  logic [7:0] m2sData;
  logic s2mValid;
  logic s2mReady;
  logic [7:0] s2mData;
  modport slave (input m2sValid, input m2sData, input s2mReady,
    output s2mValid, output s2mData);
  modport master (output m2sValid, output m2sData, output s2mReady,
    input s2mValid, input s2mData);
endinterface

// ### mbs_link_props.sv
// Purpose: wire checks on the character link between the two ends
// Assumes: one clock, master sends each request as one unbroken burst
// Notes: longest request is an ASCII two-register write of 27 chars
module mbs_link_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic m2sValid,
  input wire logic [7:0] m2sData,
  input wire logic s2mValid,
  input wire logic s2mReady,
  input wire logic [7:0] s2mData
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned runLen_ff;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Length of the request burst, read at its falling edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      runLen_ff <= 0;
    else
      runLen_ff <= m2sValid ? runLen_ff + 1 : 0;
  end
  sequence reqEnd;
    $fell(m2sValid);
  endsequence
  sequence replyHeld;
    s2mValid && !s2mReady;
  endsequence
  hold_reply_a: assert property (replyHeld |=> s2mValid)
    else $error("reply char withdrawn before taken");
  stable_char_a: assert property (replyHeld |=> $stable(s2mData))
    else $error("reply char changed while waiting");
  one_way_a: assert property (s2mValid |-> !m2sValid)
    else $error("reply overlaps a request");
  gap_first_a: assert property (reqEnd |-> !s2mValid [*2])
    else $error("reply started before the frame ended");
  req_len_a: assert property (reqEnd |-> runLen_ff >= 8 && runLen_ff <= 27)
    else $error("request burst length out of range");
  master_quiet_a: assert property (reqEnd |-> !m2sValid [*4])
    else $error("master sent again without waiting");
  reply_drain_a: assert property ($rose(s2mValid) |-> ##[1:400] !s2mValid)
    else $error("reply never drained");
  wait_reply_a: assert property (s2mValid |-> s2mReady)
    else $error("master not waiting while reply runs");
endmodule // mbs_link_props

// ### mbs_master.sv
// Purpose: master end issuing read and write requests
// Assumes: one or two registers per request
// Notes: a pair carries a 32-bit value, low word at the lower index
module mbs_master #(
  parameter int TMO_CYC = mbs_pkg::TMO_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  mbs_link_if.master lnk,
  input wire logic asciiMode,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdDev,
  input wire logic [15:0] cmdStart,
  input wire logic cmdPair,
  input wire logic [31:0] cmdData,
  output logic rspValid,
  output logic rspOk,
  output logic rspExc,
  output logic rspTimeout,
  output logic [7:0] rspCode,
  output logic [31:0] rspData
);
  import mbs_pkg::*;
  typedef enum logic [2:0] {M_IDLE, M_COLON, M_TX, M_CR, M_LF, M_WAIT} mbs_mst_e;
  mbs_mst_e st_ff;
  logic [7:0] dev_ff;
  logic [7:0] fc_ff;
  logic [15:0] start_ff;
  logic [7:0] n_ff;
  logic [31:0] data_ff;
  logic [7:0] idx_ff;
  logic ph_ff;
  logic [15:0] crc_ff;
  logic [7:0] lrc_ff;
  logic [7:0] rb_ff [9];
  logic [3:0] rc_ff;
  logic [15:0] rCrc_ff;
  logic [7:0] rLrc_ff;
  logic rPh_ff;
  logic rAct_ff;
  logic rBad_ff;
  logic [3:0] rNib_ff;
  logic [31:0] tmo_ff;
  logic [7:0] bodyLen;
  logic [7:0] lastIdx;
  logic [7:0] txByte;
  logic [7:0] k;
  logic [15:0] word;
  logic [4:0] hv;
  logic got;
  logic [7:0] rxByte;
  logic done;
  logic [7:0] expLen;

  assign cmdReady = st_ff == M_IDLE;
  assign lnk.s2mReady = st_ff == M_WAIT; // Stalls the slave FIFO otherwise

  // Request byte for the current position
  always_comb
  begin
    bodyLen = (fc_ff == FC_WRITE) ? 8'h07 + {n_ff[6:0], 1'b0} : 8'h06;
    lastIdx = asciiMode ? bodyLen : bodyLen + 8'h01;
    k = idx_ff - 8'h07;
    word = k[1] ? data_ff[31:16] : data_ff[15:0];
    case (idx_ff)
      8'h00: txByte = dev_ff;
      8'h01: txByte = fc_ff;
      8'h02: txByte = start_ff[15:8];
      8'h03: txByte = start_ff[7:0];
      8'h04: txByte = 8'h00;
      8'h05: txByte = n_ff;
      8'h06: txByte = {n_ff[6:0], 1'b0};
      default: txByte = k[0] ? word[7:0] : word[15:8];
    endcase
    if (idx_ff >= bodyLen)
      txByte = asciiMode ? 8'h00 - lrc_ff : (idx_ff == bodyLen ? crc_ff[7:0] : crc_ff[15:8]);
  end

  // Sequence and transmit side, one character per cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= M_IDLE;
      dev_ff <= 8'h00;
      fc_ff <= FC_READ;
      start_ff <= 16'h0000;
      n_ff <= 8'h01;
      data_ff <= 32'h0000_0000;
      idx_ff <= 8'h00;
      ph_ff <= 1'b0;
      crc_ff <= CRC_INIT;
      lrc_ff <= 8'h00;
      lnk.m2sValid <= 1'b0;
      lnk.m2sData <= 8'h00;
    end
    else
    begin
      lnk.m2sValid <= st_ff == M_COLON || st_ff == M_TX || st_ff == M_CR || st_ff == M_LF;
      lnk.m2sData <= asciiMode ? hexChar(ph_ff ? txByte[3:0] : txByte[7:4]) : txByte;
      case (st_ff)
        M_IDLE:
          if (cmdValid)
          begin
            dev_ff <= cmdDev;
            fc_ff <= cmdWrite ? FC_WRITE : FC_READ;
            start_ff <= cmdStart;
            n_ff <= cmdPair ? 8'h02 : 8'h01;
            data_ff <= cmdData;
            idx_ff <= 8'h00;
            ph_ff <= 1'b0;
            crc_ff <= CRC_INIT;
            lrc_ff <= 8'h00;
            st_ff <= asciiMode ? M_COLON : M_TX;
          end
        M_COLON:
        begin
          lnk.m2sData <= CH_COLON;
          st_ff <= M_TX;
        end
        M_TX:
        begin
          ph_ff <= asciiMode && !ph_ff;
          if (!asciiMode || ph_ff)
          begin
            idx_ff <= idx_ff + 8'h01;
            if (idx_ff < bodyLen)
            begin
              crc_ff <= crcStep(crc_ff, txByte);
              lrc_ff <= lrc_ff + txByte;
            end
            if (idx_ff == lastIdx)
              st_ff <= asciiMode ? M_CR : M_WAIT;
          end
        end
        M_CR:
        begin
          lnk.m2sData <= CH_CR;
          st_ff <= M_LF;
        end
        M_LF:
        begin
          lnk.m2sData <= CH_LF;
          st_ff <= M_WAIT;
        end
        default:
          if (done || tmo_ff == TMO_CYC - 1)
            st_ff <= M_IDLE;
      endcase
    end
  end

  // Reply decode and completion
  always_comb
  begin
    hv = hexVal(lnk.s2mData);
    rxByte = asciiMode ? {rNib_ff, hv[3:0]} : lnk.s2mData;
    got = lnk.s2mValid && (!asciiMode || (rAct_ff && hv[4] && rPh_ff));
    if (rb_ff[1][7])
      expLen = 8'h05;
    else if (fc_ff == FC_READ)
      expLen = 8'h05 + rb_ff[2];
    else
      expLen = 8'h08;
    if (asciiMode)
      done = lnk.s2mValid && rAct_ff && lnk.s2mData == CH_LF;
    else
      done = rc_ff >= 4'h3 && {4'h0, rc_ff} == expLen;
  end

  // Reply collection while waiting
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rc_ff <= 4'h0;
      rCrc_ff <= CRC_INIT;
      rLrc_ff <= 8'h00;
      rPh_ff <= 1'b0;
      rAct_ff <= 1'b0;
      rBad_ff <= 1'b0;
      rNib_ff <= 4'h0;
      for (int i = 0; i < 9; i++)
        rb_ff[i] <= 8'h00;
    end
    else if (st_ff != M_WAIT || done || (asciiMode && lnk.s2mValid && lnk.s2mData == CH_COLON))
    begin
      rc_ff <= 4'h0;
      rCrc_ff <= CRC_INIT;
      rLrc_ff <= 8'h00;
      rPh_ff <= 1'b0;
      rBad_ff <= 1'b0;
      rAct_ff <= st_ff == M_WAIT && !done;
      rb_ff[1] <= 8'h00;
    end
    else if (got)
    begin
      rPh_ff <= 1'b0;
      if (rc_ff < 4'h9)
      begin
        rb_ff[rc_ff] <= rxByte;
        rc_ff <= rc_ff + 4'h1;
        rCrc_ff <= crcStep(rCrc_ff, rxByte);
        rLrc_ff <= rLrc_ff + rxByte;
      end
      else
        rBad_ff <= 1'b1;
    end
    else if (asciiMode && lnk.s2mValid && rAct_ff && hv[4])
    begin
      rNib_ff <= hv[3:0];
      rPh_ff <= 1'b1;
    end
  end

  // Reply timer and result
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tmo_ff <= '0;
      rspValid <= 1'b0;
      rspOk <= 1'b0;
      rspExc <= 1'b0;
      rspTimeout <= 1'b0;
      rspCode <= 8'h00;
      rspData <= 32'h0000_0000;
    end
    else
    begin
      rspValid <= 1'b0;
      tmo_ff <= (st_ff == M_WAIT) ? tmo_ff + 1'b1 : '0;
      if (st_ff == M_WAIT && done)
      begin
        rspValid <= 1'b1;
        rspTimeout <= 1'b0;
        rspOk <= !rBad_ff && rb_ff[0] == dev_ff && (rb_ff[1] & ~EXC_BIT) == fc_ff
          && (asciiMode ? (rLrc_ff == 8'h00 && !rPh_ff) : rCrc_ff == 16'h0000);
        rspExc <= rb_ff[1][7];
        rspCode <= rb_ff[2];
        rspData <= {rb_ff[5], rb_ff[6], rb_ff[3], rb_ff[4]};
      end
      else if (st_ff == M_WAIT && tmo_ff == TMO_CYC - 1)
      begin
        rspValid <= 1'b1;
        rspTimeout <= 1'b1;
        rspOk <= 1'b0;
        rspExc <= 1'b0;
      end
    end
  end
endmodule // mbs_master

// ### mbs_pkg.sv
// Purpose: shared constants and helpers for the serial telegram link
// Assumes: one 250 MHz clock on both ends
// Notes: checksum and hex helpers are used by both ends
package mbs_pkg;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_BIT = 8'h80;
  localparam logic [7:0] EC_FUNC = 8'h01;
  localparam logic [7:0] EC_ADDR = 8'h02;
  localparam logic [7:0] EC_DATA = 8'h03;
  localparam logic [7:0] EC_DEV = 8'h04;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UF = 8'h46;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int CLK_MHZ = 250;
  // Customary fixed idle gap for fast baud rates
  localparam int GAP_US = 1750;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int TMO_US = 100000;
  localparam int TMO_CYC = TMO_US * CLK_MHZ;
  localparam int MAX_REGS = 16;
  localparam int FIFO_DEPTH = 8;

  // One byte of the reflected CRC-16
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

  // Upper-case hex digit to {valid, nibble}
  function automatic logic [4:0] hexVal(input logic [7:0] ch);
    logic [4:0] r;
    r = 5'h00;
    if (ch >= CH_ZERO && ch <= CH_NINE)
      r = {1'b1, ch[3:0]};
    else if (ch >= CH_UA && ch <= CH_UF)
      r = {1'b1, ch[3:0] + 4'h9};
    return r;
  endfunction

  function automatic logic [7:0] hexChar(input logic [3:0] n);
    return (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_UA + {4'h0, n} - 8'h0A;
  endfunction
endpackage

// ### mbs_slave.sv
// Purpose: slave telegram handler, read and write register functions
// Assumes: register file answers index checks and reads in the same cycle
// Notes: reply characters pass a FIFO; depth must be a power of two
// What this block does
// - RTU: address, function, data, two CRC bytes
// - ASCII: colon, hex pairs, LRC, CR LF
// - Read request: 0x03, start, count, CRC
// - Read reply: 0x03, count x2, data
// - Write request: 0x10, start, count, bytes, data
// - Write reply echoes start and count only
// - 16-bit values go high byte first, except the CRC, which goes low byte first
// - 32-bit values go low word first
// - Unsupported function answers error 0x01
// - Bad register index answers error 0x02
// - Bad count or length answers 0x03
// - Out-of-range write value answers 0x04
// - Error reply: address, function|0x80, code, CRC
// - Bad checksum: drop silently, no reply
// - Master times out on missing reply
module mbs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;

  // Extra pointer bit tells full from empty
  assign inReady = !((wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
  assign outValid = wp_ff != rp_ff;
  assign outData = mem_ff[rp_ff[AW-1:0]];

  // Write side
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_ff <= '0;
      for (int i = 0; i < D; i++)
        mem_ff[i] <= '0;
    end
    else if (inValid && inReady)
    begin
      mem_ff[wp_ff[AW-1:0]] <= inData;
      wp_ff <= wp_ff + 1'b1;
    end
  end

  // Read side
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rp_ff <= '0;
    else if (outValid && outReady)
      rp_ff <= rp_ff + 1'b1;
  end
endmodule // mbs_fifo

module mbs_slave #(
  parameter int MAX_REGS = mbs_pkg::MAX_REGS,
  parameter int GAP_CYC = mbs_pkg::GAP_CYC,
  parameter int FIFO_DEPTH = mbs_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  mbs_link_if.slave lnk,
  input wire logic [7:0] devAddr,
  input wire logic asciiMode,
  output logic [15:0] regIdx,
  input wire logic [15:0] regRdData,
  input wire logic regIdxOk,
  input wire logic regValOk,
  output logic regWrEn,
  output logic [15:0] regWrData
);
  import mbs_pkg::*;
  localparam int RXB = 2 * MAX_REGS + 9;
  localparam int CW = $clog2(RXB + 1);
  typedef enum logic [2:0] {ST_RX, ST_CHK, ST_WR, ST_COLON, ST_TX, ST_CR, ST_LF} mbs_st_e;
  mbs_st_e st_ff;
  logic [7:0] buf_ff [RXB];
  logic [CW-1:0] rxCnt_ff;
  logic [CW-1:0] plen_ff;
  logic [15:0] rxCrc_ff;
  logic [7:0] rxLrc_ff;
  logic [3:0] hiNib_ff;
  logic nibPh_ff;
  logic rxAct_ff;
  logic rxBad_ff;
  logic [31:0] gap_ff;
  logic [7:0] exc_ff;
  logic [15:0] idx_ff;
  logic [7:0] txIdx_ff;
  logic txPh_ff;
  logic [15:0] txCrc_ff;
  logic [7:0] txLrc_ff;
  logic [4:0] hv;
  logic gotByte;
  logic frameEnd;
  logic frameOk;
  logic [7:0] rxByte;
  logic [7:0] fmtCode;
  logic [7:0] txLen;
  logic [7:0] lastIdx;
  logic [7:0] txByte;
  logic [7:0] rdOff;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  logic byteDone;
  logic [7:0] fc;
  logic [15:0] startIdx;
  logic [15:0] num;
  logic isWr;
  mbs_st_e txStart;

  assign fc = buf_ff[1];
  assign startIdx = {buf_ff[2], buf_ff[3]};
  assign num = {buf_ff[4], buf_ff[5]};
  assign isWr = fc == FC_WRITE;
  assign txStart = asciiMode ? ST_COLON : ST_TX;

  // Incoming character decode
  always_comb
  begin
    hv = hexVal(lnk.m2sData);
    rxByte = asciiMode ? {hiNib_ff, hv[3:0]} : lnk.m2sData;
    gotByte = lnk.m2sValid && (!asciiMode || (rxAct_ff && hv[4] && nibPh_ff));
    if (asciiMode)
      frameEnd = lnk.m2sValid && rxAct_ff && lnk.m2sData == CH_LF;
    else
      frameEnd = rxCnt_ff != '0 && !lnk.m2sValid && gap_ff == GAP_CYC - 1;
    frameOk = !rxBad_ff && !nibPh_ff && buf_ff[0] == devAddr;
    if (asciiMode)
      frameOk = frameOk && rxLrc_ff == 8'h00 && rxCnt_ff >= 3;
    else
      frameOk = frameOk && rxCrc_ff == 16'h0000 && rxCnt_ff >= 4;
  end

  // Frame collection; cleared whenever the handler is busy
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rxCnt_ff <= '0;
      rxCrc_ff <= CRC_INIT;
      rxLrc_ff <= 8'h00;
      rxAct_ff <= 1'b0;
      rxBad_ff <= 1'b0;
      nibPh_ff <= 1'b0;
      hiNib_ff <= 4'h0;
      for (int i = 0; i < RXB; i++)
        buf_ff[i] <= 8'h00;
    end
    else if (st_ff != ST_RX || frameEnd || (asciiMode && lnk.m2sValid && lnk.m2sData == CH_COLON))
    begin
      rxCnt_ff <= '0;
      rxCrc_ff <= CRC_INIT;
      rxLrc_ff <= 8'h00;
      rxBad_ff <= 1'b0;
      nibPh_ff <= 1'b0;
      rxAct_ff <= st_ff == ST_RX && !frameEnd; // Colon opens a frame
    end
    else if (gotByte)
    begin
      nibPh_ff <= 1'b0;
      if (rxCnt_ff < CW'(RXB))
      begin
        buf_ff[rxCnt_ff] <= rxByte;
        rxCnt_ff <= rxCnt_ff + 1'b1;
        rxCrc_ff <= crcStep(rxCrc_ff, rxByte);
        rxLrc_ff <= rxLrc_ff + rxByte;
      end
      else
        rxBad_ff <= 1'b1; // Oversize frame is dropped
    end
    else if (asciiMode && lnk.m2sValid && rxAct_ff)
    begin
      if (hv[4])
      begin
        hiNib_ff <= hv[3:0];
        nibPh_ff <= 1'b1;
      end
      else if (lnk.m2sData != CH_CR)
        rxBad_ff <= 1'b1;
    end
  end

  // Line idle timer; RTU frames end on silence
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      gap_ff <= '0;
    else if (st_ff != ST_RX || lnk.m2sValid || frameEnd || rxCnt_ff == '0)
      gap_ff <= '0;
    else
      gap_ff <= gap_ff + 1'b1;
  end

  // Request screening before any register is touched
  always_comb
  begin
    fmtCode = 8'h00;
    if (fc != FC_READ && fc != FC_WRITE)
      fmtCode = EC_FUNC;
    else if (num == 16'h0000 || int'(num) > MAX_REGS)
      fmtCode = EC_DATA;
    else if (!isWr && plen_ff != CW'(6))
      fmtCode = EC_DATA;
    else if (isWr && (buf_ff[6] != {num[6:0], 1'b0} || int'(plen_ff) != 7 + 2 * int'(num)))
      fmtCode = EC_DATA;
  end

  // Register side: checks, writes and reply reads share one index
  always_comb
  begin
    rdOff = (txIdx_ff - 8'h03) >> 1;
    regIdx = (st_ff == ST_TX) ? startIdx + {8'h00, rdOff} : startIdx + idx_ff;
    regWrEn = st_ff == ST_WR;
    regWrData = {buf_ff[7 + 2 * int'(idx_ff[7:0])], buf_ff[8 + 2 * int'(idx_ff[7:0])]};
  end

  // Handler sequence
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_ff <= ST_RX;
      idx_ff <= 16'h0000;
      exc_ff <= 8'h00;
      plen_ff <= '0;
    end
    else
    begin
      case (st_ff)
        ST_RX:
          if (frameEnd && frameOk)
          begin
            st_ff <= ST_CHK;
            idx_ff <= 16'h0000;
            exc_ff <= 8'h00;
            plen_ff <= rxCnt_ff - (asciiMode ? CW'(1) : CW'(2));
          end
        ST_CHK:
          if (fmtCode != 8'h00)
          begin
            exc_ff <= fmtCode;
            st_ff <= txStart;
          end
          else if (!regIdxOk)
          begin
            exc_ff <= EC_ADDR;
            st_ff <= txStart;
          end
          else if (isWr && !regValOk)
          begin
            exc_ff <= EC_DEV;
            st_ff <= txStart;
          end
          else if (idx_ff == num - 1'b1)
          begin
            idx_ff <= 16'h0000;
            st_ff <= isWr ? ST_WR : txStart; // Nothing written unless all pass
          end
          else
            idx_ff <= idx_ff + 1'b1;
        ST_WR:
          if (idx_ff == num - 1'b1)
            st_ff <= txStart;
          else
            idx_ff <= idx_ff + 1'b1;
        ST_COLON:
          if (pushReady)
            st_ff <= ST_TX;
        ST_TX:
          if (pushReady && byteDone && txIdx_ff == lastIdx)
            st_ff <= asciiMode ? ST_CR : ST_RX;
        ST_CR:
          if (pushReady)
            st_ff <= ST_LF;
        ST_LF:
          if (pushReady)
            st_ff <= ST_RX;
        default:
          st_ff <= ST_RX;
      endcase
    end
  end

  // Reply byte for the current position
  always_comb
  begin
    if (exc_ff != 8'h00)
      txLen = 8'h03;
    else if (isWr)
      txLen = 8'h06;
    else
      txLen = 8'h03 + {num[6:0], 1'b0};
    lastIdx = asciiMode ? txLen : txLen + 8'h01;
    byteDone = !asciiMode || txPh_ff;
    if (txIdx_ff == 8'h00)
      txByte = devAddr;
    else if (txIdx_ff == 8'h01)
      txByte = (exc_ff != 8'h00) ? (fc | EXC_BIT) : fc;
    else if (txIdx_ff == 8'h02 && exc_ff != 8'h00)
      txByte = exc_ff;
    else if (txIdx_ff == 8'h02 && !isWr)
      txByte = {num[6:0], 1'b0};
    else if (txIdx_ff < txLen && isWr)
      txByte = buf_ff[txIdx_ff[2:0]];
    else if (txIdx_ff < txLen)
      // Registers go out in index order; the low word of a pair sits first
      txByte = (txIdx_ff[0]) ? regRdData[15:8] : regRdData[7:0];
    else if (asciiMode)
      txByte = 8'h00 - txLrc_ff;
    else if (txIdx_ff == txLen)
      txByte = txCrc_ff[7:0];
    else
      txByte = txCrc_ff[15:8];
    pushValid = st_ff == ST_COLON || st_ff == ST_TX || st_ff == ST_CR || st_ff == ST_LF;
    if (st_ff == ST_COLON)
      pushData = CH_COLON;
    else if (st_ff == ST_CR)
      pushData = CH_CR;
    else if (st_ff == ST_LF)
      pushData = CH_LF;
    else if (asciiMode)
      pushData = hexChar(txPh_ff ? txByte[3:0] : txByte[7:4]);
    else
      pushData = txByte;
  end

  // Reply position and running checksums; full FIFO stalls here
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      txIdx_ff <= 8'h00;
      txPh_ff <= 1'b0;
      txCrc_ff <= CRC_INIT;
      txLrc_ff <= 8'h00;
    end
    else if (st_ff != ST_TX && st_ff != ST_COLON)
    begin
      txIdx_ff <= 8'h00;
      txPh_ff <= 1'b0;
      txCrc_ff <= CRC_INIT;
      txLrc_ff <= 8'h00;
    end
    else if (st_ff == ST_TX && pushReady)
    begin
      txPh_ff <= asciiMode && !txPh_ff;
      if (byteDone)
      begin
        txIdx_ff <= txIdx_ff + 8'h01;
        if (txIdx_ff < txLen)
        begin
          txCrc_ff <= crcStep(txCrc_ff, txByte);
          txLrc_ff <= txLrc_ff + txByte;
        end
      end
    end
  end

  // Reply characters queue toward the master
  mbs_fifo #(.W(8), .D(FIFO_DEPTH)) uFifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(lnk.s2mValid),
    .outReady(lnk.s2mReady),
    .outData(lnk.s2mData)
  );
endmodule // mbs_slave

// ### tb_top.sv
// Purpose: bench for master and slave joined on one link
// Assumes: short gap and timeout parameters
// Notes: register file is an 8-entry array behind the slave
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mbs_pkg::*;
  localparam logic [15:0] BASE = 16'h6000;
  localparam logic [7:0] DEV = 8'h01;
  logic clk, resetn, asciiMode, cmdValid, cmdReady, cmdWrite, cmdPair;
  logic rspValid, rspOk, rspExc, rspTimeout, regWrEn;
  logic [7:0] cmdDev, rspCode;
  logic [15:0] cmdStart, regIdx, regWrData, s;
  logic [31:0] cmdData, rspData, rnd;
  logic [15:0] rf[8];
  logic [15:0] mdl[8];
  logic [7:0] wq[$];
  int n_mismatch, cmp_count;
  mbs_link_if lnk();
  mbs_master #(.TMO_CYC(2000)) mbs_master_i (.clk(clk), .resetn(resetn), .lnk(lnk),
    .asciiMode(asciiMode), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite),
    .cmdDev(cmdDev), .cmdStart(cmdStart), .cmdPair(cmdPair), .cmdData(cmdData),
    .rspValid(rspValid), .rspOk(rspOk), .rspExc(rspExc), .rspTimeout(rspTimeout),
    .rspCode(rspCode), .rspData(rspData));
  // Index window of eight registers; all-ones is an illegal value
  mbs_slave #(.GAP_CYC(20)) mbs_slave_i (.clk(clk), .resetn(resetn), .lnk(lnk),
    .devAddr(DEV), .asciiMode(asciiMode), .regIdx(regIdx), .regRdData(rf[regIdx[2:0]]),
    .regIdxOk(regIdx[15:3] == BASE[15:3]), .regValOk(regWrData != 16'hFFFF),
    .regWrEn(regWrEn), .regWrData(regWrData));
  mbs_link_props mbs_link_props_i (.clk(clk), .resetn(resetn), .m2sValid(lnk.m2sValid),
    .m2sData(lnk.m2sData), .s2mValid(lnk.s2mValid), .s2mReady(lnk.s2mReady),
    .s2mData(lnk.s2mData));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Register file writes and request capture off the wire
  always @(posedge clk)
  begin
    if (regWrEn === 1'b1)
      rf[regIdx[2:0]] <= regWrData;
    if (lnk.m2sValid === 1'b1)
      wq.push_back(lnk.m2sData);
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] r;
    r = v ^ (v << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Request held until taken; a missing response ends the run
  task automatic doCmd(input logic w, input logic [7:0] dv, input logic [15:0] st,
    input logic [31:0] d);
    int i;
    wq.delete();
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdDev = dv;
    cmdStart = st;
    cmdData = d;
    // Ready is looked at off the edge, so the value seen is the one the edge will take
    for (i = 0; i < 3000; i++)
    begin
      if (cmdReady === 1'b1)
        break;
      @(posedge clk);
      #1;
    end
    if (i == 3000)
    begin
      n_mismatch++;
      $display("[FAIL] ready exp 1 got 0");
      wrap_up();
    end
    @(posedge clk);
    #1 cmdValid = 1'b0;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      #1;
      if (rspValid === 1'b1)
        break;
    end
    if (i == 3000)
    begin
      n_mismatch++;
      $display("[FAIL] response exp 1 got 0");
      wrap_up();
    end
  endtask
  initial
  begin
    rnd = 32'haced_5163;
    {resetn, asciiMode, cmdValid, cmdWrite, cmdDev, cmdStart, cmdData} = '0;
    cmdPair = 1'b1;
    foreach (rf[i])
    begin
      rf[i] = 16'h0000;
      mdl[i] = 16'h0000;
    end
    repeat (20) @(posedge clk);
    #1 resetn = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      asciiMode = m[0];
      // Random pair writes, read back at random start
      repeat (4)
      begin
        rnd = xs(rnd);
        s = BASE + {13'h0000, 3'(rnd[2:0] % 3'h7)};
        rnd = xs(rnd);
        doCmd(1'b1, DEV, s, rnd & 32'h7FFF_7FFF);
        chk("write ok", 32'h1, rspOk);
        chk("write echo", {8'h02, s, 8'h00}, {rspData[31:24], rspCode, rspData[15:0]});
        chk("write len", (m == 0) ? 32'h0000_000D : 32'h0000_001B, 32'(wq.size()));
        mdl[s[2:0]] = rnd[15:0] & 16'h7FFF;
        mdl[s[2:0] + 3'h1] = rnd[31:16] & 16'h7FFF;
        doCmd(1'b0, DEV, s, 32'h0000_0000);
        chk("read ok", 32'h1, rspOk);
        chk("read data", {mdl[s[2:0] + 3'h1], mdl[s[2:0]]}, rspData);
        if (m == 0)
          chk("rtu req", {DEV, FC_READ, s}, {wq[0], wq[1], wq[2], wq[3]});
        else
          chk("ascii req", {8'h3A, hx(DEV[7:4]), 16'h0D0A}, {wq[0], wq[1], wq[$-1], wq[$]});
      end
      // Single register at the top of the window
      cmdPair = 1'b0;
      rnd = xs(rnd);
      mdl[7] = rnd[15:0] & 16'h7FFF;
      doCmd(1'b1, DEV, BASE + 16'h0007, {16'h0000, mdl[7]});
      chk("single write", 32'h1, rspOk);
      doCmd(1'b0, DEV, BASE + 16'h0007, 32'h0000_0000);
      chk("single read", {16'h0000, mdl[7]}, {16'h0000, rspData[15:0]});
      cmdPair = 1'b1;
      // Pair straddling the top of the window, bad value, no write, other address
      doCmd(1'b0, DEV, BASE + 16'h0007, 32'h0000_0000);
      chk("bad index", 32'h0102, {23'h0, rspExc, rspCode});
      doCmd(1'b1, DEV, BASE, 32'h1234_FFFF);
      chk("bad value", 32'h0104, {23'h0, rspExc, rspCode});
      doCmd(1'b0, DEV, BASE, 32'h0000_0000);
      chk("no write", {mdl[1], mdl[0]}, rspData);
      doCmd(1'b0, DEV + 8'h01, BASE, 32'h0000_0000);
      chk("other addr", 32'h1, rspTimeout);
    end
    wrap_up();
  end
endmodule // tb_top
